// ===== rtl/hbra_access.v
// Purpose: Host buffer RAM access path: status, read-back lengths, word ports
// Assumes: One command strobe opens an access, data strobes follow one by one
// Notes: Engine side of the RAM is a plain byte port; end of transfer is a pulse
//        Port reads prefetch: the RAM address runs one cycle ahead of the pointer
//        Buffer bases are 0, L and 2L; L must be even so words stay aligned
//        A command in the cycle of a last word suppresses that end pulse
//        A word write always lands at the current pointer of the open buffer
// Overview of operation
// - Status bits 5,4,3 show ack list, iso1, iso0 consumed by the engine.
// - Status bits 2,1,0 show ack list, iso1, iso0 buffers full.
// - Command 2DH reads iso0 pending read-back byte count, reset zero.
// - Command 2EH reads iso1 pending read-back byte count, reset zero.
// - Iso port word: high byte even address, low byte odd address.
// - Ack list port word: high byte odd address, low byte even address.
// - Iso port opened once by 40H read or C0H write, then words stream.
// - Ack port opened once by 41H read or C1H write, then words stream.
// - Each iso port word access advances that buffer pointer by two bytes.
// - Each ack port word access advances that buffer pointer by two bytes.
// - Reaching the transfer count raises end of transfer and updates status.
`timescale 1ns/1ps
`include "hbra_defs.vh"
`default_nettype none

module hbra_access (
    input wire clock_in,
    input wire rstn_in,
    input wire cmd_wr_in,
    input wire [15:0] bus_data_in,
    input wire data_wr_in,
    input wire data_rd_in,
    output reg [15:0] bus_data_out,
    output wire port_ready_out,
    input wire [15:0] transfer_byte_counter_in,
    input wire [15:0] iso_buffer_length_in,
    input wire iso_select_in,
    input wire [`HBRA_NBUF-1:0] engine_consumed_in,
    input wire [1:0] pending_load_in,
    input wire [15:0] pending_bytes_in,
    input wire [`HBRA_ADDR_W-1:0] engine_addr_in,
    input wire engine_wr_in,
    input wire [7:0] engine_wdata_in,
    output wire [7:0] engine_rdata_out,
    output reg all_transfers_ended_out,
    output wire [15:0] host_buffer_status_out
);

    // Sequencer and pointer state
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [1:0] buf_reg;
    reg [15:0] offset_reg;
    reg [15:0] count_reg;
    // Read-back lengths and buffer flags
    reg [15:0] iso0_pending_bytes_reg;
    reg [15:0] iso1_pending_bytes_reg;
    reg [`HBRA_NBUF-1:0] full_reg;
    reg [`HBRA_NBUF-1:0] consumed_reg;
    // Combinational helpers
    reg [`HBRA_NBUF-1:0] end_wr_ev;
    reg [`HBRA_NBUF-1:0] end_rd_ev;
    reg [15:0] base_addr;
    reg [15:0] status_word;
    reg [1:0] addr_buf;
    reg [15:0] addr_offset;

    // Decode and datapath nets
    wire [7:0] cmd_code;
    wire port_open;
    wire is_port_cmd;
    wire is_ack_cmd;
    wire is_write_cmd;
    wire [1:0] cmd_buf;
    wire [15:0] offset_plus;
    wire [15:0] remaining;
    wire last_word;
    wire one_byte_left;
    wire word_done;
    wire [15:0] byte_addr;
    wire ack_sel;
    wire [7:0] ram_even_q;
    wire [7:0] ram_odd_q;
    wire [7:0] wr_even;
    wire [7:0] wr_odd;
    wire we_even;
    wire we_odd;
    wire [15:0] read_word;

    // Command code rides in the low byte of the bus word
    assign cmd_code = bus_data_in[7:0];

    // Port command decode
    assign is_port_cmd = (cmd_code == `HBRA_CMD_ISO_PORT_RD) || (cmd_code == `HBRA_CMD_ISO_PORT_WR) ||
        (cmd_code == `HBRA_CMD_ACK_PORT_RD) || (cmd_code == `HBRA_CMD_ACK_PORT_WR);
    assign is_ack_cmd = (cmd_code == `HBRA_CMD_ACK_PORT_RD) || (cmd_code == `HBRA_CMD_ACK_PORT_WR);
    assign is_write_cmd = (cmd_code == `HBRA_CMD_ISO_PORT_WR) || (cmd_code == `HBRA_CMD_ACK_PORT_WR);
    assign cmd_buf = is_ack_cmd ? 2'h2 : (iso_select_in ? 2'h1 : 2'h0);

    // A port command opens a stream at the start of its buffer
    assign port_open = cmd_wr_in && is_port_cmd;

    // RAM buffer select one cycle ahead; a word write uses the open buffer
    always @* begin
        addr_buf = buf_reg;
        if (port_open && !we_even) begin
            addr_buf = cmd_buf;
        end
    end

    // RAM offset one cycle ahead, so the fetch edge sees the addressed word
    always @* begin
        addr_offset = offset_reg;
        if (we_even) begin
            addr_offset = offset_reg;
        end else if (port_open) begin
            addr_offset = `HBRA_ZERO16;
        end else if (word_done) begin
            addr_offset = offset_plus;
        end
    end

    // Buffer start addresses: iso0, then iso1, then the ack list
    always @* begin
        case (addr_buf)
            2'h0: base_addr = `HBRA_ZERO16;
            2'h1: base_addr = iso_buffer_length_in;
            2'h2: base_addr = iso_buffer_length_in + iso_buffer_length_in;
            default: base_addr = `HBRA_ZERO16;
        endcase
    end

    // Pointer arithmetic against the latched byte count
    assign offset_plus = offset_reg + `HBRA_WORD_STEP;
    assign remaining = count_reg - offset_reg;
    assign last_word = (offset_plus >= count_reg);
    assign one_byte_left = (remaining == `HBRA_ONE_BYTE);
    assign byte_addr = base_addr + addr_offset;
    assign ack_sel = (buf_reg == 2'h2);

    // A word is consumed on a data strobe in a streaming state
    assign word_done = ((state_reg == `HBRA_S_READ) && data_rd_in) ||
        ((state_reg == `HBRA_S_WRITE) && data_wr_in);

    // Byte lane mapping into the RAM banks
    assign wr_even = ack_sel ? bus_data_in[7:0] : bus_data_in[15:8];
    assign wr_odd = ack_sel ? bus_data_in[15:8] : bus_data_in[7:0];
    assign we_even = (state_reg == `HBRA_S_WRITE) && data_wr_in;
    assign we_odd = we_even && !one_byte_left;
    assign read_word = ack_sel ? {ram_odd_q, ram_even_q} : {ram_even_q, ram_odd_q};

    // Only a port read waits; the fetch cycle holds the processor off
    assign port_ready_out = (state_reg != `HBRA_S_FETCH);

    // Status word, reserved bits read zero
    always @* begin
        status_word = `HBRA_ZERO16;
        status_word[`HBRA_ST_ISO0_FULL] = full_reg[`HBRA_BUF_ISO0];
        status_word[`HBRA_ST_ISO1_FULL] = full_reg[`HBRA_BUF_ISO1];
        status_word[`HBRA_ST_ACK_FULL] = full_reg[`HBRA_BUF_ACK];
        status_word[`HBRA_ST_ISO0_DONE] = consumed_reg[`HBRA_BUF_ISO0];
        status_word[`HBRA_ST_ISO1_DONE] = consumed_reg[`HBRA_BUF_ISO1];
        status_word[`HBRA_ST_ACK_DONE] = consumed_reg[`HBRA_BUF_ACK];
    end

    // Status leaves the block unregistered
    assign host_buffer_status_out = status_word;

    // End-of-transfer events per buffer and direction
    always @* begin
        end_wr_ev = {`HBRA_NBUF{1'b0}};
        end_rd_ev = {`HBRA_NBUF{1'b0}};
        if (word_done && last_word) begin
            if (state_reg == `HBRA_S_WRITE) begin
                end_wr_ev[buf_reg] = 1'b1;
            end else begin
                end_rd_ev[buf_reg] = 1'b1;
            end
        end
    end

    // Sequencer next state
    always @* begin
        state_next = state_reg;
        if (cmd_wr_in) begin
            if (is_port_cmd) begin
                state_next = is_write_cmd ? `HBRA_S_WRITE : `HBRA_S_FETCH;
            end else begin
                state_next = `HBRA_S_IDLE;
            end
        end else begin
            case (state_reg)
                `HBRA_S_IDLE: state_next = `HBRA_S_IDLE;
                `HBRA_S_FETCH: state_next = `HBRA_S_READ;
                `HBRA_S_READ: begin
                    if (data_rd_in) begin
                        state_next = last_word ? `HBRA_S_IDLE : `HBRA_S_FETCH;
                    end
                end
                `HBRA_S_WRITE: begin
                    if (data_wr_in && last_word) begin
                        state_next = `HBRA_S_IDLE;
                    end
                end
                default: state_next = `HBRA_S_IDLE;
            endcase
        end
    end

    // Sequencer, pointer and end-of-transfer pulse
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= `HBRA_S_IDLE;
            buf_reg <= 2'h0;
            offset_reg <= `HBRA_ZERO16;
            count_reg <= `HBRA_ZERO16;
            all_transfers_ended_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            all_transfers_ended_out <= word_done && last_word && !cmd_wr_in;
            if (cmd_wr_in && is_port_cmd) begin
                buf_reg <= cmd_buf;
                offset_reg <= `HBRA_ZERO16;
                count_reg <= transfer_byte_counter_in;
            end else if (word_done) begin
                offset_reg <= offset_plus;
            end
        end
    end

    // Read data register: register reads load at the command, port words at fetch
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_data_out <= `HBRA_ZERO16;
        end else if (cmd_wr_in) begin
            case (cmd_code)
                `HBRA_CMD_STATUS_RD: bus_data_out <= status_word;
                `HBRA_CMD_ISO0_LEN_RD: bus_data_out <= iso0_pending_bytes_reg;
                `HBRA_CMD_ISO1_LEN_RD: bus_data_out <= iso1_pending_bytes_reg;
                default: bus_data_out <= bus_data_out;
            endcase
        end else if (state_reg == `HBRA_S_FETCH) begin
            bus_data_out <= read_word;
        end
    end

    // Read-back lengths written by the engine side
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            iso0_pending_bytes_reg <= `HBRA_ZERO16;
            iso1_pending_bytes_reg <= `HBRA_ZERO16;
        end else begin
            if (pending_load_in[0]) begin
                iso0_pending_bytes_reg <= pending_bytes_in;
            end
            if (pending_load_in[1]) begin
                iso1_pending_bytes_reg <= pending_bytes_in;
            end
        end
    end

    // Per-buffer flags; a setting event wins over a clearing one
    genvar gi;
    generate
        for (gi = 0; gi < `HBRA_NBUF; gi = gi + 1) begin : g_flag
            always @(posedge clock_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    full_reg[gi] <= 1'b0;
                    consumed_reg[gi] <= 1'b0;
                end else begin
                    // Written data makes the buffer full; engine use or read-back empties it
                    full_reg[gi] <= end_wr_ev[gi] ||
                        (full_reg[gi] && !engine_consumed_in[gi] && !end_rd_ev[gi]);
                    // Engine use marks consumed; fresh data clears it
                    consumed_reg[gi] <= engine_consumed_in[gi] ||
                        (consumed_reg[gi] && !end_wr_ev[gi]);
                end
            end
        end
    endgenerate

    // Shared buffer RAM
    hbra_ram u_ram (
        .clock_in(clock_in),
        .a_addr_in(byte_addr[`HBRA_ADDR_W-1:1]),
        .a_we_even_in(we_even),
        .a_we_odd_in(we_odd),
        .a_even_in(wr_even),
        .a_odd_in(wr_odd),
        .a_even_out(ram_even_q),
        .a_odd_out(ram_odd_q),
        .b_addr_in(engine_addr_in),
        .b_we_in(engine_wr_in),
        .b_wdata_in(engine_wdata_in),
        .b_rdata_out(engine_rdata_out)
    );

endmodule // hbra_access

`default_nettype wire

// ===== rtl/hbra_defs.vh
// Purpose: Shared constants of the host buffer RAM access block
// Assumes: Included by bare name from every design file of the block
// Notes: Definitions only
`ifndef HBRA_DEFS_VH
`define HBRA_DEFS_VH

// Command codes on the processor bus
`define HBRA_CMD_STATUS_RD 8'h2C
`define HBRA_CMD_ISO0_LEN_RD 8'h2D
`define HBRA_CMD_ISO1_LEN_RD 8'h2E
`define HBRA_CMD_ISO_PORT_RD 8'h40
`define HBRA_CMD_ISO_PORT_WR 8'hC0
`define HBRA_CMD_ACK_PORT_RD 8'h41
`define HBRA_CMD_ACK_PORT_WR 8'hC1

// Buffer status bit positions
`define HBRA_ST_ISO0_FULL 0
`define HBRA_ST_ISO1_FULL 1
`define HBRA_ST_ACK_FULL 2
`define HBRA_ST_ISO0_DONE 3
`define HBRA_ST_ISO1_DONE 4
`define HBRA_ST_ACK_DONE 5

// Buffer indices used by the flag vectors
`define HBRA_BUF_ISO0 0
`define HBRA_BUF_ISO1 1
`define HBRA_BUF_ACK 2
`define HBRA_NBUF 3

// Widths and steps
`define HBRA_ADDR_W 12
`define HBRA_WADDR_W 11
`define HBRA_RAM_WORDS 2048
`define HBRA_WORD_STEP 16'h0002
`define HBRA_ONE_BYTE 16'h0001
`define HBRA_ZERO16 16'h0000

// Port sequencer states
`define HBRA_S_IDLE 2'h0
`define HBRA_S_FETCH 2'h1
`define HBRA_S_READ 2'h2
`define HBRA_S_WRITE 2'h3

`endif

// ===== rtl/hbra_ram.v
// Purpose: Shared byte-organised buffer RAM, split in even and odd byte banks
// Assumes: Single clock, synchronous read with one cycle latency
// Notes: Port A is word wide for the processor, port B byte wide for the engine
`timescale 1ns/1ps
`include "hbra_defs.vh"
`default_nettype none

module hbra_ram (
    input wire clock_in,
    input wire [`HBRA_WADDR_W-1:0] a_addr_in,
    input wire a_we_even_in,
    input wire a_we_odd_in,
    input wire [7:0] a_even_in,
    input wire [7:0] a_odd_in,
    output reg [7:0] a_even_out,
    output reg [7:0] a_odd_out,
    input wire [`HBRA_ADDR_W-1:0] b_addr_in,
    input wire b_we_in,
    input wire [7:0] b_wdata_in,
    output reg [7:0] b_rdata_out
);

    reg [7:0] even_mem [0:`HBRA_RAM_WORDS-1];
    reg [7:0] odd_mem [0:`HBRA_RAM_WORDS-1];
    wire [`HBRA_WADDR_W-1:0] b_word;
    wire b_odd;

    assign b_word = b_addr_in[`HBRA_ADDR_W-1:1];
    assign b_odd = b_addr_in[0];

    // Processor word side and engine byte side in one process; the engine write lands last on a collision
    always @(posedge clock_in) begin
        if (a_we_even_in) begin
            even_mem[a_addr_in] <= a_even_in;
        end
        if (a_we_odd_in) begin
            odd_mem[a_addr_in] <= a_odd_in;
        end
        if (b_we_in && !b_odd) begin
            even_mem[b_word] <= b_wdata_in;
        end
        if (b_we_in && b_odd) begin
            odd_mem[b_word] <= b_wdata_in;
        end
        a_even_out <= even_mem[a_addr_in];
        a_odd_out <= odd_mem[a_addr_in];
        b_rdata_out <= b_odd ? odd_mem[b_word] : even_mem[b_word];
    end

endmodule // hbra_ram

`default_nettype wire

// ===== verification/hbra_access_props.sv
// Purpose: Port-level checks of the buffer access block
// Assumes: Single clock, asynchronous active-low reset
// Notes: Mirrors the open stream to judge end of transfer
`timescale 1ns/1ps
`default_nettype none
module hbra_access_props (
    input wire clock_in,
    input wire rstn_in,
    input wire cmd_wr_in,
    input wire [15:0] bus_data_in,
    input wire data_wr_in,
    input wire data_rd_in,
    input wire [15:0] bus_data_out,
    input wire port_ready_out,
    input wire [15:0] transfer_byte_counter_in,
    input wire [2:0] engine_consumed_in,
    input wire [1:0] pending_load_in,
    input wire [15:0] pending_bytes_in,
    input wire all_transfers_ended_out,
    input wire [15:0] host_buffer_status_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    logic act_q, wrm_q;
    logic [15:0] wds_q, cnt_q, len0_q, len1_q;
    wire [7:0] code = bus_data_in[7:0];
    wire port_cmd = cmd_wr_in && (code[6:1] == 6'h20);
    // Open stream, words moved and read-back lengths
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            act_q <= 1'b0;
            wrm_q <= 1'b0;
            wds_q <= 16'h0000;
            cnt_q <= 16'h0000;
            len0_q <= 16'h0000;
            len1_q <= 16'h0000;
        end else begin
            if (pending_load_in[0]) len0_q <= pending_bytes_in;
            if (pending_load_in[1]) len1_q <= pending_bytes_in;
            if (cmd_wr_in) begin
                act_q <= port_cmd;
                wrm_q <= code[7];
                wds_q <= 16'h0000;
                cnt_q <= transfer_byte_counter_in;
            end else if (all_transfers_ended_out) begin
                act_q <= 1'b0;
            end else if (act_q && (wrm_q ? data_wr_in : data_rd_in && port_ready_out)) begin
                wds_q <= wds_q + 16'h0001;
            end
        end
    end
    status_read_a: assert property (cmd_wr_in && code == 8'h2C |=>
        bus_data_out == $past(host_buffer_status_out)) else $error("status read wrong");
    reserved_zero_a: assert property (host_buffer_status_out[15:6] == 10'h000)
        else $error("reserved status bits set");
    iso0_len_a: assert property (cmd_wr_in && code == 8'h2D |=> bus_data_out == $past(len0_q))
        else $error("iso0 length wrong");
    iso1_len_a: assert property (cmd_wr_in && code == 8'h2E |=> bus_data_out == $past(len1_q))
        else $error("iso1 length wrong");
    read_fetch_a: assert property (port_cmd && !code[7] |=> !port_ready_out ##1 port_ready_out)
        else $error("read fetch timing wrong");
    end_at_count_a: assert property (act_q |-> all_transfers_ended_out ==
        (({wds_q, 1'b0} >= {1'b0, cnt_q}) && wds_q != 16'h0000)) else $error("end of transfer misplaced");
    end_cause_a: assert property (all_transfers_ended_out |-> act_q && $past(data_wr_in || data_rd_in))
        else $error("end without a data strobe");
    end_pulse_a: assert property (all_transfers_ended_out |=> !all_transfers_ended_out)
        else $error("end pulse too long");
    write_full_a: assert property (all_transfers_ended_out && wrm_q |-> host_buffer_status_out[2:0] != 3'h0)
        else $error("write end left no buffer full");
    consumed_set_a: assert property (engine_consumed_in != 3'h0 |=>
        (host_buffer_status_out[5:3] & $past(engine_consumed_in)) == $past(engine_consumed_in))
        else $error("consumed flag not set");
endmodule // hbra_access_props
bind hbra_access hbra_access_props chk (.clock_in(clock_in), .rstn_in(rstn_in), .cmd_wr_in(cmd_wr_in),
    .bus_data_in(bus_data_in), .data_wr_in(data_wr_in), .data_rd_in(data_rd_in), .bus_data_out(bus_data_out),
    .port_ready_out(port_ready_out), .transfer_byte_counter_in(transfer_byte_counter_in),
    .engine_consumed_in(engine_consumed_in), .pending_load_in(pending_load_in),
    .pending_bytes_in(pending_bytes_in), .all_transfers_ended_out(all_transfers_ended_out),
    .host_buffer_status_out(host_buffer_status_out));
`default_nettype wire

// ===== verification/hbra_host_model.sv
// Purpose: Processor-side driver of the buffer access block
// Assumes: Drives at falling edges, the block samples at rising edges
// Notes: Bus data is inverted whenever no strobe qualifies it
`timescale 1ns/1ps
`default_nettype none
module hbra_host_model (
    input wire logic clock_in,
    input wire logic [15:0] bus_data_out,
    input wire logic port_ready_out,
    output logic cmd_wr_out,
    output logic [15:0] bus_data_wr_out,
    output logic data_wr_out,
    output logic data_rd_out,
    output logic [15:0] byte_count_out,
    output logic iso_select_out
);
    // Idle bus at time zero
    initial begin
        cmd_wr_out = 1'b0;
        data_wr_out = 1'b0;
        data_rd_out = 1'b0;
        bus_data_wr_out = 16'h5AA5;
        byte_count_out = 16'h0000;
        iso_select_out = 1'b0;
    end
    // Byte count and buffer choice, then one command write
    task automatic command(input logic [7:0] code, input logic [15:0] count, input logic sel);
        @(negedge clock_in);
        byte_count_out = count;
        iso_select_out = sel;
        bus_data_wr_out = {8'h00, code};
        cmd_wr_out = 1'b1;
        @(negedge clock_in);
        cmd_wr_out = 1'b0;
        bus_data_wr_out = ~bus_data_wr_out;
    endtask
    // Back-to-back word writes without a new command
    task automatic write_words(input logic [15:0] w0, input logic [15:0] w1, input int n);
        @(negedge clock_in);
        for (int i = 0; i < n; i++) begin
            bus_data_wr_out = (i == 0) ? w0 : w1;
            data_wr_out = 1'b1;
            @(negedge clock_in);
        end
        data_wr_out = 1'b0;
        bus_data_wr_out = ~bus_data_wr_out;
    endtask
    // Take the presented word once ready, bounded wait
    task automatic read_word(output logic [15:0] w, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (port_ready_out === 1'b1) begin
                ok = 1'b1;
                break;
            end
            @(negedge clock_in);
        end
        w = bus_data_out;
        data_rd_out = ok;
        @(negedge clock_in);
        data_rd_out = 1'b0;
    endtask
endmodule // hbra_host_model
`default_nettype wire

// ===== verification/hbra_access_tb.sv
// Purpose: Self-checking bench of the buffer access block
// Assumes: Host model drives the processor side at falling edges
// Notes: Buffers are 16 bytes each, iso1 at 10H, ack list at 20H
`timescale 1ns/1ps
`default_nettype none
module hbra_access_tb;
    logic clock_in, rstn_in, iso_sel, cmd_wr, data_wr, data_rd, eng_wr, ready, ended;
    logic [15:0] bus_wr, bus_rd, count, pend_bytes, status, word;
    logic [11:0] eng_addr;
    logic [7:0] eng_wdata, eng_rdata;
    logic [2:0] consumed;
    logic [1:0] pend_load;
    bit ok;
    int checks = 0;
    int n_fail = 0;
    hbra_access uut (.clock_in(clock_in), .rstn_in(rstn_in), .cmd_wr_in(cmd_wr), .bus_data_in(bus_wr),
        .data_wr_in(data_wr), .data_rd_in(data_rd), .bus_data_out(bus_rd), .port_ready_out(ready),
        .transfer_byte_counter_in(count), .iso_buffer_length_in(16'h0010),
        .iso_select_in(iso_sel), .engine_consumed_in(consumed), .pending_load_in(pend_load),
        .pending_bytes_in(pend_bytes), .engine_addr_in(eng_addr), .engine_wr_in(eng_wr),
        .engine_wdata_in(eng_wdata), .engine_rdata_out(eng_rdata), .all_transfers_ended_out(ended),
        .host_buffer_status_out(status));
    hbra_host_model host (.clock_in(clock_in), .bus_data_out(bus_rd), .port_ready_out(ready),
        .cmd_wr_out(cmd_wr), .bus_data_wr_out(bus_wr), .data_wr_out(data_wr), .data_rd_out(data_rd),
        .byte_count_out(count), .iso_select_out(iso_sel));
    // 125 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic reg_rd(input logic [7:0] code, input logic [15:0] exp);
        host.command(code, 16'h0000, 1'b0);
        cmp(bus_rd, exp);
    endtask
    task automatic wr_chk(input logic [7:0] code, input logic [15:0] n_bytes, input logic sel,
        input logic [15:0] w0, input logic [15:0] w1, input int n, input logic end_exp);
        host.command(code, n_bytes, sel);
        host.write_words(w0, w1, n);
        cmp({15'h0000, ended}, {15'h0000, end_exp});
    endtask
    task automatic rd_chk(input logic [15:0] exp, input logic [15:0] mask, input logic end_exp);
        host.read_word(word, ok);
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: read word never ready", $time);
            close_out;
        end
        cmp(word & mask, exp);
        cmp({15'h0000, ended}, {15'h0000, end_exp});
    endtask
    task automatic eng_chk(input logic [11:0] a, input logic [7:0] e);
        eng_addr = a;
        @(negedge clock_in);
        cmp({8'h00, eng_rdata}, {8'h00, e});
    endtask
    task automatic engine_pulse(input logic [2:0] c, input logic [1:0] ld, input logic [15:0] v);
        consumed = c;
        pend_load = ld;
        pend_bytes = v;
        @(negedge clock_in);
        consumed = 3'h0;
        pend_load = 2'h0;
    endtask
    // Main sequence
    initial begin
        rstn_in = 1'b0;
        consumed = 3'h0;
        pend_load = 2'h0;
        pend_bytes = 16'h0000;
        eng_addr = 12'h000;
        eng_wr = 1'b0;
        eng_wdata = 8'h00;
        repeat (4) @(negedge clock_in);
        cmp(status, 16'h0000);
        rstn_in = 1'b1;
        reg_rd(8'h2D, 16'h0000);
        reg_rd(8'h2E, 16'h0000);
        host.command(8'h33, 16'h0000, 1'b0);
        cmp(bus_rd, 16'h0000);
        done("reset");
        wr_chk(8'hC0, 16'h0004, 1'b0, 16'hA1B2, 16'hC3D4, 2, 1'b1);
        eng_chk(12'h000, 8'hA1);
        eng_chk(12'h003, 8'hD4);
        eng_addr = 12'h023;
        eng_wdata = 8'h5A;
        eng_wr = 1'b1;
        @(negedge clock_in);
        eng_wr = 1'b0;
        wr_chk(8'hC1, 16'h0003, 1'b0, 16'h1122, 16'h3344, 2, 1'b1);
        eng_chk(12'h020, 8'h22);
        eng_chk(12'h021, 8'h11);
        eng_chk(12'h022, 8'h44);
        eng_chk(12'h023, 8'h5A);
        reg_rd(8'h2C, 16'h0005);
        done("write");
        engine_pulse(3'h0, 2'h1, 16'h0004);
        reg_rd(8'h2D, 16'h0004);
        host.command(8'h40, bus_rd, 1'b0);
        rd_chk(16'hA1B2, 16'hFFFF, 1'b0);
        rd_chk(16'hC3D4, 16'hFFFF, 1'b1);
        host.command(8'h41, 16'h0003, 1'b0);
        rd_chk(16'h1122, 16'hFFFF, 1'b0);
        rd_chk(16'h0044, 16'h00FF, 1'b1);
        reg_rd(8'h2C, 16'h0000);
        done("read");
        engine_pulse(3'h7, 2'h0, 16'h0000);
        reg_rd(8'h2C, 16'h0038);
        wr_chk(8'hC0, 16'h0002, 1'b1, 16'hBEEF, 16'h0000, 1, 1'b1);
        eng_chk(12'h010, 8'hBE);
        reg_rd(8'h2C, 16'h002A);
        engine_pulse(3'h0, 2'h2, 16'h0002);
        reg_rd(8'h2E, 16'h0002);
        host.command(8'h40, bus_rd, 1'b1);
        rd_chk(16'hBEEF, 16'hFFFF, 1'b1);
        reg_rd(8'h2C, 16'h0028);
        done("status");
        wr_chk(8'hC0, 16'h0006, 1'b0, 16'h0102, 16'h0000, 1, 1'b0);
        repeat (3) @(negedge clock_in);
        cmp({15'h0000, ended}, 16'h0000);
        wr_chk(8'hC0, 16'h0002, 1'b0, 16'h0304, 16'h0000, 1, 1'b1);
        eng_chk(12'h000, 8'h03);
        eng_chk(12'h002, 8'hC3);
        reg_rd(8'h2C, 16'h0021);
        done("restart");
        close_out;
    end
endmodule // hbra_access_tb
`default_nettype wire
